// ### core/tbp_regs.svh
// Register indices, field positions, reset values and bus codes for the port
`ifndef TBP_REGS_SVH
`define TBP_REGS_SVH

// Register indices; byte address is four times the index
`define TBP_IDX_DIR        16'hFFC9
`define TBP_IDX_DATA       16'hFFCB
`define TBP_IDX_BRC        16'hFFE0
`define TBP_IDX_WCE        16'hFFE1
`define TBP_IDX_WCR        16'hFFE2

// Reset values
`define TBP_RST_DIR        8'h80
`define TBP_RST_DATA       8'h80
`define TBP_RST_WCE        8'hFF
`define TBP_RST_BUS_RELEASE_ENABLE       1'h0
`define TBP_RST_WMS        1'h0

// Read value of the write-only direction register
`define TBP_DIR_READ       8'hFF

// Field positions
`define TBP_PIN_GRANT      2
`define TBP_PIN_REQ        1
`define TBP_PIN_WAIT       0
`define TBP_BUS_RELEASE_ENABLE_BIT       0
`define TBP_WMS_BIT        1
`define TBP_FIXED_BIT      7
`define TBP_RSV_HI         6
`define TBP_RSV_LO         3
`define TBP_WCE_ALL        8'hFF

// Bus answers
`define TBP_RESP_OKAY      2'h0
`define TBP_RESP_SLVERR    2'h2

`endif

// ### core/tbp_pkg.sv
// Types shared by the three-bit port files
package tbp_pkg;
    typedef enum logic [2:0] {
        TBP_SEL_NONE,
        TBP_SEL_DIR,
        TBP_SEL_DATA,
        TBP_SEL_BRC,
        TBP_SEL_WCE,
        TBP_SEL_WCR
    } tbp_sel_t;
endpackage : tbp_pkg

// ### core/tbp_sync.sv
// Two-flop synchroniser bank for the port pin inputs
`timescale 1ns/1ps
module tbp_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    stage1[g]   <= 1'b1;
                    sync_out[g] <= 1'b1;
                end else begin
                    stage1[g]   <= async_in[g];
                    sync_out[g] <= stage1[g];
                end
            end
        end
    endgenerate
endmodule : tbp_sync

// ### core/tbp_port.sv
// Three-bit port with bus control pin sharing and AXI4-Lite register access
//
// Functional notes
// - Three two-way pins 2..0 serve either as plain I/O or as a bus control signal.
// - The pin sharing is the same in every operating mode; no mode input exists.
// - In plain I/O use a direction bit of 1 drives the pin and 0 makes it an input.
// - The 8-bit direction register is write-only and always reads all ones.
// - Direction resets to 0x80 on reset and hardware standby and holds in software standby.
// - In software standby a pin whose direction bit is 1 keeps driving.
// - A data read returns the stored bit for pins whose direction bit is 1.
// - A data read returns the synchronised pin level for pins whose direction bit is 0.
// - Data bit 7 reads 1 on input reads; bits 6 to 3 carry no defined pin value.
// - Data bits 6 to 3 are plain storage, writable and readable, tied to no pin.
// - Data bit 7 is fixed at 1 and ignores writes.
// - Data resets to 0x80 on reset and hardware standby and holds in software standby.
// - With bus release enabled pin 2 drives grant acknowledge and pin 1 takes bus request.
// - Pin 0 is picked by the area wait enables, upper wait mode bit and its direction bit.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tbp_regs.svh"
module tbp_port
    import tbp_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Standby controls
    input  wire logic        hw_standby,
    input  wire logic        sw_standby,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Port pins
    input  wire logic [2:0]  pin_i,
    output logic      [2:0]  pin_o,
    output logic      [2:0]  pin_oe,
    // Bus control functions
    input  wire logic        bus_grant_ack_n,
    output logic             bus_request_n,
    output logic             wait_request_n,
    output logic             wait_pin_selected
);

    function automatic tbp_sel_t decode(input logic [31:0] addr);
        tbp_sel_t s;
        s = TBP_SEL_NONE;
        if (addr[1:0] == 2'h0 && addr[31:18] == 14'h0000) begin
            unique case (addr[17:2])
                `TBP_IDX_DIR:  s = TBP_SEL_DIR;
                `TBP_IDX_DATA: s = TBP_SEL_DATA;
                `TBP_IDX_BRC:  s = TBP_SEL_BRC;
                `TBP_IDX_WCE:  s = TBP_SEL_WCE;
                `TBP_IDX_WCR:  s = TBP_SEL_WCR;
                default:       s = TBP_SEL_NONE;
            endcase
        end
        return s;
    endfunction : decode

    // Registers
    logic [7:0]  pin_direction;
    logic [7:0]  pin_data;
    logic        bus_release_enable;
    logic [7:0]  per_area_wait_enables;
    logic        wait_mode_select_upper;

    // Write channel holding
    logic        aw_full;
    logic [31:0] aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    logic [2:0]  pin_sync;

    tbp_sync #(
        .WIDTH    (3)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_i),
        .sync_out (pin_sync)
    );

    // Handshakes and decode
    wire         aw_hs      = s_axi_awvalid && s_axi_awready;
    wire         w_hs       = s_axi_wvalid && s_axi_wready;
    wire         ar_hs      = s_axi_arvalid && s_axi_arready;
    wire         do_write   = aw_full && w_full && !s_axi_bvalid;
    wire         lane0      = w_strb[0];
    wire tbp_sel_t wr_sel   = decode(aw_addr);
    wire tbp_sel_t rd_sel   = decode(s_axi_araddr);
    wire         wr_dir     = do_write && lane0 && wr_sel == TBP_SEL_DIR;
    wire         wr_data    = do_write && lane0 && wr_sel == TBP_SEL_DATA;
    wire         wr_brc     = do_write && lane0 && wr_sel == TBP_SEL_BRC;
    wire         wr_wce     = do_write && lane0 && wr_sel == TBP_SEL_WCE;
    wire         wr_wcr     = do_write && lane0 && wr_sel == TBP_SEL_WCR;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready  = !w_full;
    assign s_axi_arready = !s_axi_rvalid;

    // Pin function selection, no mode input takes part
    wire         wait_sel   = (per_area_wait_enables != `TBP_WCE_ALL) || wait_mode_select_upper;
    assign wait_pin_selected = wait_sel;

    // Pin 2: grant acknowledge or plain I/O
    assign pin_oe[`TBP_PIN_GRANT] = bus_release_enable || pin_direction[`TBP_PIN_GRANT];
    assign pin_o[`TBP_PIN_GRANT]  = bus_release_enable ? bus_grant_ack_n : pin_data[`TBP_PIN_GRANT];
    // Pin 1: bus request input or plain I/O
    assign pin_oe[`TBP_PIN_REQ]   = !bus_release_enable && pin_direction[`TBP_PIN_REQ];
    assign pin_o[`TBP_PIN_REQ]    = pin_data[`TBP_PIN_REQ];
    assign bus_request_n          = bus_release_enable ? pin_sync[`TBP_PIN_REQ] : 1'b1;
    // Pin 0: wait request input or plain I/O; software standby leaves drive alone
    assign pin_oe[`TBP_PIN_WAIT]  = !wait_sel && pin_direction[`TBP_PIN_WAIT];
    assign pin_o[`TBP_PIN_WAIT]   = pin_data[`TBP_PIN_WAIT];
    assign wait_request_n         = wait_sel ? pin_sync[`TBP_PIN_WAIT] : 1'b1;

    // Data read: stored bit for outputs, pin level for inputs
    wire [2:0]   pin_view   = (pin_direction[2:0] & pin_data[2:0]) | (~pin_direction[2:0] & pin_sync);
    wire [7:0]   data_view  = {1'b1, pin_data[`TBP_RSV_HI:`TBP_RSV_LO], pin_view};

    logic [7:0]  rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (rd_sel)
            TBP_SEL_DIR:  rd_byte = `TBP_DIR_READ;
            TBP_SEL_DATA: rd_byte = data_view;
            TBP_SEL_BRC:  rd_byte = {7'h00, bus_release_enable};
            TBP_SEL_WCE:  rd_byte = per_area_wait_enables;
            TBP_SEL_WCR:  rd_byte = {6'h00, wait_mode_select_upper, 1'b0};
            TBP_SEL_NONE: rd_byte = 8'h00;
        endcase
    end

    // Write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_addr <= 32'h0000_0000;
        end else if (aw_hs) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (w_hs) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_full <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TBP_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_sel == TBP_SEL_NONE) ? `TBP_RESP_SLVERR : `TBP_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `TBP_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= (rd_sel == TBP_SEL_NONE) ? `TBP_RESP_SLVERR : `TBP_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Port registers; software standby has no effect on them
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_standby) begin
            pin_direction <= `TBP_RST_DIR;
        end else if (wr_dir) begin
            pin_direction <= w_data[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || hw_standby) begin
            pin_data <= `TBP_RST_DATA;
        end else if (wr_data) begin
            pin_data <= {1'b1, w_data[6:0]};
        end
    end

    // Bus control settings
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_standby) begin
            bus_release_enable     <= `TBP_RST_BUS_RELEASE_ENABLE;
            per_area_wait_enables  <= `TBP_RST_WCE;
            wait_mode_select_upper <= `TBP_RST_WMS;
        end else begin
            if (wr_brc) begin
                bus_release_enable <= w_data[`TBP_BUS_RELEASE_ENABLE_BIT];
            end
            if (wr_wce) begin
                per_area_wait_enables <= w_data[7:0];
            end
            if (wr_wcr) begin
                wait_mode_select_upper <= w_data[`TBP_WMS_BIT];
            end
        end
    end

    // Checks
    logic        rd_was_dir;
    logic        rd_was_data;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_was_dir  <= 1'b0;
            rd_was_data <= 1'b0;
        end else if (ar_hs) begin
            rd_was_dir  <= rd_sel == TBP_SEL_DIR;
            rd_was_data <= rd_sel == TBP_SEL_DATA;
        end
    end

    dir_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && rd_was_dir |-> s_axi_rdata[7:0] == `TBP_DIR_READ)
        else $error("direction read not all ones");

    dir_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) || $past(hw_standby) |-> pin_direction == `TBP_RST_DIR && pin_data == `TBP_RST_DATA)
        else $error("port registers not at 0x80 after reset or standby");

    standby_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sw_standby && !hw_standby && !do_write |=> $stable(pin_data) && $stable(pin_direction))
        else $error("registers changed in software standby");

    drive_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_direction[0] && !wait_sel |-> pin_oe[0] && pin_o[0] == pin_data[0])
        else $error("pin 0 not driving its data");

    out_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_hs && rd_sel == TBP_SEL_DATA && pin_direction[2] |=> s_axi_rdata[2] == $past(pin_data[2]))
        else $error("output pin read not from stored bit");

    in_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_hs && rd_sel == TBP_SEL_DATA && !pin_direction[1] |=> s_axi_rdata[1] == $past(pin_sync[1]))
        else $error("input pin read not from pin level");

    fixed_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && rd_was_data |-> s_axi_rdata[7] && pin_data[7])
        else $error("data bit 7 not one");

    rsv_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_data && !hw_standby |=> pin_data[6:3] == $past(w_data[6:3]))
        else $error("reserved data bits not stored");

    bus_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bus_release_enable |-> pin_oe[2] && !pin_oe[1] && pin_o[2] == bus_grant_ack_n)
        else $error("bus release pin roles wrong");

    wait_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wait_sel |-> !pin_oe[0] && wait_request_n == pin_sync[0])
        else $error("wait pin driven while selected");

    write_resp_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_dir ##1 s_axi_bvalid);
    read_data_c:  cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && rd_was_data);
    release_c:    cover property (@(posedge aclk) disable iff (!aresetn) $rose(bus_release_enable));
    wait_c:       cover property (@(posedge aclk) disable iff (!aresetn) $rose(wait_sel));

endmodule : tbp_port

// ### tb/tbp_pin_model.sv
// Behavioural model of the devices wired to the three port pins
`timescale 1ns/1ps
module tbp_pin_model (
    // Pins as seen from the port
    input  wire logic [2:0] pin_o,
    input  wire logic [2:0] pin_oe,
    output logic      [2:0] pin_i,
    // Levels the outside world wants to drive
    input  wire logic [2:0] ext_val,
    input  wire logic [2:0] ext_en
);
    // Outside drives only pins the port has released; bus request and wait request come in here
    always @(pin_o or pin_oe or ext_val or ext_en) begin
        for (int b = 0; b < 3; b++) begin
            if (pin_oe[b])
                pin_i[b] = pin_o[b];
            else if (ext_en[b])
                pin_i[b] = ext_val[b];
            else
                pin_i[b] = (pin_i[b] === 1'b1) ? 1'b0 : 1'b1;
        end
    end
endmodule : tbp_pin_model

// ### tb/three_bit_port_bus_ctrl_mux_tb_top.sv
// Testbench for the three-bit port with bus control sharing
`timescale 1ns/1ps
`include "tbp_regs.svh"
module three_bit_port_bus_ctrl_mux_tb_top;
    import tbp_pkg::*;
    logic        aclk, aresetn, hw_standby, sw_standby, grant_n;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, resp;
    logic [2:0]  pin_i, pin_o, pin_oe, ext_val, ext_en;
    logic        req_n, wait_n, wait_sel;
    logic [31:0] rd;
    int          error_cnt, checked;
    localparam logic [31:0] A_DIR = {14'h0, `TBP_IDX_DIR, 2'h0};
    localparam logic [31:0] A_DAT = {14'h0, `TBP_IDX_DATA, 2'h0};
    localparam logic [31:0] A_BRC = {14'h0, `TBP_IDX_BRC, 2'h0};
    localparam logic [31:0] A_WCE = {14'h0, `TBP_IDX_WCE, 2'h0};
    localparam logic [31:0] A_WCR = {14'h0, `TBP_IDX_WCR, 2'h0};

    tbp_port dut (.aclk(aclk), .aresetn(aresetn), .hw_standby(hw_standby), .sw_standby(sw_standby),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .bus_grant_ack_n(grant_n),
        .bus_request_n(req_n), .wait_request_n(wait_n), .wait_pin_selected(wait_sel));
    tbp_pin_model partner (.pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i), .ext_val(ext_val), .ext_en(ext_en));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        checked++;
        if ((got & mask) !== (exp & mask)) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got & mask, exp & mask);
        end
    endtask : chk

    task automatic hang();
        error_cnt++;
        $display("[FAIL] %0t bus wait ran out", $time);
        finish_test();
    endtask : hang

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_done, w_done, aw_r, w_r, bv;
        int   n;
        aw_done = 1'b0;
        w_done = 1'b0;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_done && w_done)) begin
            #1;
            aw_r = awready;
            w_r = wready;
            @(posedge aclk);
            if (!aw_done && aw_r) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && w_r) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            if (++n > 50) hang();
        end
        do begin
            #1;
            bv = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (++n > 100) hang();
        end while (!bv);
        bready <= 1'b0;
        #1;
    endtask : wr

    task automatic rdr(input logic [31:0] a);
        logic ar_r, rv;
        int   n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            #1;
            ar_r = arready;
            @(posedge aclk);
            if (++n > 50) hang();
        end while (!ar_r);
        arvalid <= 1'b0;
        do begin
            #1;
            rv = rvalid;
            rd = rdata;
            resp = rresp;
            @(posedge aclk);
            if (++n > 100) hang();
        end while (!rv);
        rready <= 1'b0;
        #1;
    endtask : rdr

    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask : settle

    initial begin
        error_cnt = 0;
        checked = 0;
        aresetn = 1'b0;
        hw_standby = 1'b0;
        sw_standby = 1'b0;
        grant_n = 1'b1;
        awaddr = '0;
        wdata = '0;
        wstrb = '0;
        araddr = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        ext_val = 3'h6;
        ext_en = 3'h7;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        chk(pin_oe, 32'h0, 32'h7);
        rdr(A_DIR);
        chk(rd, 32'hFF, 32'hFFFFFFFF);
        chk(resp, `TBP_RESP_OKAY, 32'h3);
        rdr(A_DAT);
        chk(rd, 32'h86, 32'h87);
        // Outputs with reserved storage and the fixed top bit
        wr(A_DIR, 32'h07);
        chk(resp, `TBP_RESP_OKAY, 32'h3);
        wr(A_DAT, 32'h7D);
        chk(pin_oe, 32'h7, 32'h7);
        chk(pin_o, 32'h5, 32'h7);
        rdr(A_DAT);
        chk(rd, 32'hFD, 32'hFF);
        rdr(A_DIR);
        chk(rd, 32'hFF, 32'hFF);
        sw_standby <= 1'b1;
        settle();
        chk(pin_oe, 32'h7, 32'h7);
        chk(pin_o, 32'h5, 32'h7);
        rdr(A_DAT);
        chk(rd, 32'hFD, 32'hFF);
        sw_standby <= 1'b0;
        // Inputs, then a mix of inputs and outputs
        wr(A_DIR, 32'h00);
        ext_val = 3'h5;
        settle();
        chk(pin_oe, 32'h0, 32'h7);
        rdr(A_DAT);
        chk(rd, 32'h85, 32'h87);
        wr(A_DIR, 32'h05);
        ext_val = 3'h2;
        settle();
        rdr(A_DAT);
        chk(rd, 32'h87, 32'h87);
        // Hardware standby restores reset values
        @(posedge aclk) hw_standby <= 1'b1;
        @(posedge aclk) hw_standby <= 1'b0;
        #1;
        chk(pin_oe, 32'h0, 32'h7);
        wr(A_DIR, 32'h07);
        rdr(A_DAT);
        chk(rd, 32'h80, 32'h87);
        // Bus release takes over pins 2 and 1
        wr(A_BRC, 32'h01);
        grant_n <= 1'b0;
        #1;
        chk(pin_oe, 32'h5, 32'h7);
        chk(pin_o, 32'h0, 32'h4);
        @(posedge aclk) grant_n <= 1'b1;
        #1;
        chk(pin_o, 32'h4, 32'h4);
        ext_val = 3'h0;
        settle();
        chk(req_n, 32'h0, 32'h1);
        ext_val = 3'h2;
        settle();
        chk(req_n, 32'h1, 32'h1);
        wr(A_BRC, 32'h00);
        chk(pin_oe, 32'h7, 32'h7);
        chk(pin_o, 32'h0, 32'h4);
        // Pin 1 now drives 0; the request output must stay idle
        settle();
        chk(req_n, 32'h1, 32'h1);
        // Wait request selection on pin 0
        chk(wait_sel, 32'h0, 32'h1);
        chk(pin_oe, 32'h1, 32'h1);
        wr(A_WCE, 32'hFE);
        chk(wait_sel, 32'h1, 32'h1);
        chk(pin_oe, 32'h0, 32'h1);
        ext_val = 3'h0;
        settle();
        chk(wait_n, 32'h0, 32'h1);
        ext_val = 3'h1;
        settle();
        chk(wait_n, 32'h1, 32'h1);
        wr(A_WCE, 32'hFF);
        chk(wait_sel, 32'h0, 32'h1);
        wr(A_WCR, 32'h02);
        chk(wait_sel, 32'h1, 32'h1);
        wr(A_WCR, 32'h00);
        chk(wait_sel, 32'h0, 32'h1);
        // Pin 0 now drives 0; the wait output must stay idle
        settle();
        chk(wait_n, 32'h1, 32'h1);
        // Unmapped place answers with an error
        wr(32'h100, 32'h1);
        chk(resp, `TBP_RESP_SLVERR, 32'h3);
        rdr(32'h100);
        chk(resp, `TBP_RESP_SLVERR, 32'h3);
        finish_test();
    end
endmodule : three_bit_port_bus_ctrl_mux_tb_top
